// file: hw/sar_adc_sequencer.sv
// successive-approximation converter control with axi4-lite registers
// assumes: comparator answer valid one step after the trial code is shown
//
// Contract
// - ladder splits span into 256 steps
// - code zero gives zero, else n-half step
// - control bits 1:0 pick input channel
// - completion stores result, sets done flag; sets shared flag only when route bit set
// - start leaves shared flag; software clears it
// - writing zero to done bit starts
// - start clears result register to zero
// - msb trial set, kept if below input
// - conversion ends within 50 machine cycles
// - interrupt asserted with completion flag update
// - done bit reads zero throughout conversion
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog front end
  input wire logic comp_above,
  output logic [1:0] channel_select,
  output logic [7:0] ladder_code,
  output logic ladder_connect,
  // external interrupt source sharing the request flag
  input wire logic external_interrupt_three,
  // interrupt
  output logic irq
);

  sar_adc_pkg::ctrl_t ctrl;
  sar_adc_pkg::seq_state_t state;
  logic done;
  logic [7:0] result;
  logic [7:0] trial_bit;
  logic [7:0] step_cnt;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_fire;
  logic start;
  logic finish;
  logic ext_prev;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  // write channel capture, either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sar_adc_pkg::resp_okay;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == sar_adc_pkg::ctrl_addr || aw_addr == sar_adc_pkg::irq_status_addr
          || aw_addr == sar_adc_pkg::irq_mask_addr)
        s_axi_bresp <= sar_adc_pkg::resp_okay;
      else if (aw_addr == sar_adc_pkg::result_addr || aw_addr == sar_adc_pkg::trial_addr)
        s_axi_bresp <= sar_adc_pkg::resp_okay;
      else
        s_axi_bresp <= sar_adc_pkg::resp_slverr;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  assign start = wr_fire && aw_addr == sar_adc_pkg::ctrl_addr && w_strb[0]
                 && !w_data[sar_adc_pkg::done_bit];

  // control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl.chan <= sar_adc_pkg::ctrl_reset[sar_adc_pkg::chan_msb:sar_adc_pkg::chan_lsb];
      ctrl.ladder_on <= sar_adc_pkg::ctrl_reset[sar_adc_pkg::ladder_bit];
      ctrl.route_adc <= sar_adc_pkg::ctrl_reset[sar_adc_pkg::route_bit];
    end
    else if (wr_fire && aw_addr == sar_adc_pkg::ctrl_addr && w_strb[0])
    begin
      ctrl.chan <= w_data[sar_adc_pkg::chan_msb:sar_adc_pkg::chan_lsb];
      ctrl.ladder_on <= w_data[sar_adc_pkg::ladder_bit];
      ctrl.route_adc <= w_data[sar_adc_pkg::route_bit];
    end
  end

  assign channel_select = ctrl.chan;
  assign ladder_connect = ctrl.ladder_on;

  // front end maps code n to (n-0.5) steps
  assign ladder_code = result;

  // a restart on the last decide wins, so no flags for the dropped result
  assign finish = !start && state == sar_adc_pkg::decide_st && step_cnt == 8'h00
                  && trial_bit[0];

  // sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= sar_adc_pkg::idle_st;
      result <= sar_adc_pkg::result_reset;
      trial_bit <= 8'h00;
      step_cnt <= 8'h00;
      done <= sar_adc_pkg::ctrl_reset[sar_adc_pkg::done_bit];
    end
    else if (start)
    begin
      result <= 8'h00;
      trial_bit <= 8'h80;
      step_cnt <= sar_adc_pkg::step_count;
      done <= 1'b0;
      state <= sar_adc_pkg::trial_st;
    end
    else
    begin
      case (state)
        sar_adc_pkg::idle_st:
        begin
          step_cnt <= 8'h00;
        end
        sar_adc_pkg::trial_st:
        begin
          result <= result | trial_bit;
          step_cnt <= sar_adc_pkg::step_count;
          state <= sar_adc_pkg::decide_st;
        end
        sar_adc_pkg::decide_st:
        begin
          if (step_cnt != 8'h00)
            step_cnt <= step_cnt - 8'h01;
          else
          begin
            // keep bit only if below input
            if (!comp_above)
              result <= result & ~trial_bit;
            trial_bit <= trial_bit >> 1;
            // 8 steps of one machine cycle
            if (trial_bit[0])
            begin
              done <= 1'b1;
              state <= sar_adc_pkg::idle_st;
            end
            else
              state <= sar_adc_pkg::trial_st;
          end
        end
        default:
          state <= sar_adc_pkg::idle_st;
      endcase
    end
  end

  // shared flag source follows routing bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_prev <= 1'b0;
    else
      ext_prev <= external_interrupt_three;
  end

  always_comb
  begin
    irq_set = 2'h0;
    irq_set[sar_adc_pkg::irq_done_bit] = finish;
    if (ctrl.route_adc)
      irq_set[sar_adc_pkg::irq_shared_bit] = finish;
    else
      irq_set[sar_adc_pkg::irq_shared_bit] = external_interrupt_three && !ext_prev;
    irq_clr = 2'h0;
    if (wr_fire && aw_addr == sar_adc_pkg::irq_status_addr && w_strb[0])
      irq_clr = w_data[1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status <= sar_adc_pkg::irq_reset;
    else
      irq_status <= (irq_status & ~irq_clr) | irq_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask <= sar_adc_pkg::irq_reset;
    else if (wr_fire && aw_addr == sar_adc_pkg::irq_mask_addr && w_strb[0])
      irq_mask <= w_data[1:0];
  end

  assign irq = |(irq_status & irq_mask);

  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sar_adc_pkg::resp_okay;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= sar_adc_pkg::resp_okay;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr == sar_adc_pkg::ctrl_addr)
        s_axi_rdata <= {24'h000000, ctrl.route_adc, 2'h0, ctrl.ladder_on, done, 1'b0,
                        ctrl.chan};
      else if (s_axi_araddr == sar_adc_pkg::result_addr)
        s_axi_rdata <= {24'h000000, done ? result : 8'h00};
      else if (s_axi_araddr == sar_adc_pkg::irq_status_addr)
        s_axi_rdata <= {30'h0, irq_status};
      else if (s_axi_araddr == sar_adc_pkg::irq_mask_addr)
        s_axi_rdata <= {30'h0, irq_mask};
      else if (s_axi_araddr == sar_adc_pkg::trial_addr)
        s_axi_rdata <= {24'h000000, result};
      else
        s_axi_rresp <= sar_adc_pkg::resp_slverr;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : sar_adc_sequencer

`default_nettype wire

// file: inc/sar_adc_pkg.sv
// constants and types for the successive-approximation converter sequencer
// assumes: one 250 MHz clock, axi4-lite register access, 32-bit data
package sar_adc_pkg;

  // register byte addresses
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] result_addr = 8'h04;
  localparam logic [7:0] irq_status_addr = 8'h08;
  localparam logic [7:0] irq_mask_addr = 8'h0c;
  localparam logic [7:0] trial_addr = 8'h10;

  // control register field positions
  localparam int chan_lsb = 0;
  localparam int chan_msb = 1;
  localparam int done_bit = 3;
  localparam int ladder_bit = 4;
  localparam int route_bit = 7;

  // reset values
  localparam logic [7:0] ctrl_reset = 8'h08;
  localparam logic [7:0] result_reset = 8'h00;
  localparam logic [1:0] irq_reset = 2'h0;

  // interrupt status layout
  localparam int irq_done_bit = 0;
  localparam int irq_shared_bit = 1;

  // ladder
  localparam int ladder_steps = 256;
  localparam int res_bits = 8;

  // timing: one machine cycle per bit step; 50 machine cycles is the ceiling
  localparam int clk_mhz = 250;
  localparam int osc_mhz = 8;
  localparam int machine_cycle_ns = 250;
  localparam int max_machine_cycles = 50;
  localparam int step_cycles = machine_cycle_ns * clk_mhz / 1000;
  localparam logic [7:0] step_count = 8'(step_cycles - 1);

  // axi responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum {idle_st, trial_st, decide_st} seq_state_t;

  typedef struct packed {
    logic [1:0] chan;
    logic ladder_on;
    logic route_adc;
  } ctrl_t;

endpackage : sar_adc_pkg

// file: test/sar_adc_props.sv
// port properties of the converter sequencer
// assumes: bound into sar_adc_sequencer, one clock
`timescale 1ns/1ps
`default_nettype none
module sar_adc_props
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register writes
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  // analog front end
  input wire logic [1:0] channel_select,
  input wire logic [7:0] ladder_code,
  input wire logic ladder_connect
);
  logic wr_ctrl;
  logic [3:0] wr_hist;
  assign wr_ctrl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_wstrb[0] && (s_axi_awaddr == sar_adc_pkg::ctrl_addr);
  // recent control writes, so mirrored outputs may follow them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wr_hist <= 4'h0;
    else
      wr_hist <= {wr_hist[2:0], wr_ctrl};
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_start;
    wr_ctrl && !s_axi_wdata[sar_adc_pkg::done_bit];
  endsequence
  sequence s_msb;
    ladder_code == 8'h00 ##1 ladder_code == 8'h80;
  endsequence
  AST_CHAN_HOLD: assert property ($changed(channel_select) |-> wr_hist != 4'h0)
    else $error("channel moved without a control write");
  AST_LADDER_HOLD: assert property ($changed(ladder_connect) |-> wr_hist != 4'h0)
    else $error("ladder supply moved without a control write");
  AST_START_CLEAR: assert property (s_start |-> ##[1:4] ladder_code == 8'h00)
    else $error("start did not clear the code");
  AST_MSB_TRIAL: assert property (s_start |-> ##[1:4] s_msb)
    else $error("msb trial missing after start");
  AST_RESTART: assert property (s_start and ladder_code != 8'h00 |-> ##[1:4] s_msb)
    else $error("restart did not begin from zero");
  AST_MSB_FROM_ZERO: assert property ($rose(ladder_code[7])
    |-> $past(ladder_code) == 8'h00)
    else $error("msb set on an uncleared code");
  AST_BIT6_TRIAL: assert property ($past(ladder_code) == 8'h80 && ladder_code[6]
    |-> ladder_code[5:0] == 6'h00)
    else $error("lower bits set early");
  AST_ONE_STEP: assert property ($changed(ladder_code) && ladder_code != 8'h00
    && $past(ladder_code) != 8'h00
    |-> $countones(ladder_code ^ $past(ladder_code)) <= 2)
    else $error("more than one bit decided per step");
endmodule : sar_adc_props

bind sar_adc_sequencer sar_adc_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .channel_select(channel_select), .ladder_code(ladder_code),
  .ladder_connect(ladder_connect));
`default_nettype wire

// file: test/sar_adc_sequencer_tb_top.sv
// self-checking bench for the converter sequencer
// assumes: comparator modelled from a target code, bus responses always accepted
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ladder_code;
  logic [7:0] analog_input_voltage = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, comp_above = 1'b0;
  logic external_interrupt_three = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, ladder_connect;
  logic [1:0] s_axi_bresp, s_axi_rresp, channel_select, rd_resp, wr_resp;
  int fail_count = 0, samples_checked = 0;

  sar_adc_sequencer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .comp_above(comp_above), .channel_select(channel_select),
    .ladder_code(ladder_code), .ladder_connect(ladder_connect),
    .external_interrupt_three(external_interrupt_three), .irq(irq));

  always #2 aclk = ~aclk;
  // ladder tap below input while code <= target
  always @(posedge aclk)
    comp_above <= (ladder_code <= analog_input_voltage);

  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic tmo;
    fail_count++;
    $display("ERROR %0t: timeout", $time);
    complete_run();
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    ta = 1'b0;
    tw = 1'b0;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 100 && !tb; n++)
    begin
      @(negedge aclk);
      tb = ta && tw && s_axi_bvalid;
      wr_resp = s_axi_bresp;
      ta = ta || s_axi_awready;
      tw = tw || s_axi_wready;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end
    if (!tb)
      tmo();
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    int n;
    ta = 1'b0;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100 && !tr; n++)
    begin
      @(negedge aclk);
      tr = ta && s_axi_rvalid;
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      ta = ta || s_axi_arready;
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'b0;
    end
    if (!tr)
      tmo();
  endtask : rd

  // bound is 50 machine cycles of 62.5 clocks
  task automatic wait_irq;
    int n;
    for (n = 0; n < 3125 && irq !== 1'b1; n++)
      @(negedge aclk);
    if (irq !== 1'b1)
      tmo();
  endtask : wait_irq

  task automatic t_reset;
    rd(sar_adc_pkg::ctrl_addr);
    chk(rd_data, 32'h08);
    rd(sar_adc_pkg::result_addr);
    chk(rd_data, 32'h0);
    rd(8'h20);
    chk({30'h0, rd_resp}, {30'h0, sar_adc_pkg::resp_slverr});
    wr(8'h20, 32'h0);
    chk({30'h0, wr_resp}, {30'h0, sar_adc_pkg::resp_slverr});
    s_axi_wstrb <= 4'h0;
    wr(sar_adc_pkg::ctrl_addr, 32'h0);
    s_axi_wstrb <= 4'hf;
    rd(sar_adc_pkg::ctrl_addr);
    chk(rd_data, 32'h08);
  endtask : t_reset

  task automatic t_conv(input logic [7:0] v);
    analog_input_voltage <= v;
    wr(sar_adc_pkg::irq_mask_addr, 32'h3);
    wr(sar_adc_pkg::ctrl_addr, 32'h92);
    chk({30'h0, wr_resp}, {30'h0, sar_adc_pkg::resp_okay});
    @(negedge aclk);
    chk({30'h0, channel_select}, 32'h2);
    chk({31'h0, ladder_connect}, 32'h1);
    rd(sar_adc_pkg::ctrl_addr);
    chk(rd_data & 32'h8, 32'h0);
    rd(sar_adc_pkg::trial_addr);
    chk(rd_data, 32'h80);
    wait_irq();
    rd(sar_adc_pkg::irq_status_addr);
    chk(rd_data, 32'h3);
    rd(sar_adc_pkg::ctrl_addr);
    chk(rd_data & 32'h8, 32'h8);
    wr(sar_adc_pkg::ctrl_addr, 32'h8a);
    @(negedge aclk);
    chk({31'h0, ladder_connect}, 32'h0);
    rd(sar_adc_pkg::result_addr);
    chk(rd_data, {24'h0, v});
    wr(sar_adc_pkg::irq_status_addr, 32'h3);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_conv

  task automatic t_restart;
    analog_input_voltage <= 8'h33;
    wr(sar_adc_pkg::ctrl_addr, 32'h92);
    repeat (100) @(posedge aclk);
    analog_input_voltage <= 8'h5c;
    wr(sar_adc_pkg::ctrl_addr, 32'h92);
    wait_irq();
    rd(sar_adc_pkg::ctrl_addr);
    chk(rd_data & 32'h8, 32'h8);
    rd(sar_adc_pkg::result_addr);
    chk(rd_data, 32'h5c);
    wr(sar_adc_pkg::irq_status_addr, 32'h3);
  endtask : t_restart

  task automatic t_shared;
    wr(sar_adc_pkg::irq_mask_addr, 32'h1);
    wr(sar_adc_pkg::ctrl_addr, 32'h18);
    external_interrupt_three <= 1'b1;
    repeat (4) @(posedge aclk);
    external_interrupt_three <= 1'b0;
    rd(sar_adc_pkg::irq_status_addr);
    chk(rd_data, 32'h2);
    chk({31'h0, irq}, 32'h0);
    analog_input_voltage <= 8'h7e;
    wr(sar_adc_pkg::ctrl_addr, 32'h10);
    rd(sar_adc_pkg::irq_status_addr);
    chk(rd_data, 32'h2);
    wait_irq();
    rd(sar_adc_pkg::irq_status_addr);
    chk(rd_data, 32'h3);
    wr(sar_adc_pkg::irq_status_addr, 32'h3);
    rd(sar_adc_pkg::irq_status_addr);
    chk(rd_data, 32'h0);
  endtask : t_shared

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_conv(8'h00);
    t_conv(8'ha5);
    t_conv(8'hff);
    t_restart();
    t_shared();
    complete_run();
  end
endmodule : sar_adc_sequencer_tb_top
`default_nettype wire
